/* File: src/fsb_defines.svh */
// constants for the flash sector security and boot configuration block
// assumes byte addresses on the register bus, low 8 bits decoded
// Notes on behaviour
// - one three-bit security byte per sector
// - read-protected sector returns invalid code bytes
// - read-protect bit erased only with its sector
// - program/erase lock blocks program and page erase
// - erase lock: only external global erase
// - read-protected sector CRC flags, aborts, invalidates
// - global CRC aborts if any read-protect
// - read-protect alone never flags program/erase
// - lock blocks program/page erase, sector erase allowed
// - erase lock blocks program, page, sector erase
// - boot vector five bits, default all ones
// - boot address is vector high, 00h low
// - boot select forces boot vector after reset
// - write guard clear forces write enable set
// - write guard set: enable via commands only
// - config guard refuses config byte writes
// - guard set by programming, cleared by key
// - clear lock rejects clear command in-system
// - clear lock cleared only by external clear
`ifndef FSB_DEFINES_SVH
`define FSB_DEFINES_SVH
`define FSB_NSEC 16
`define FSB_SEC_LSB 10
`define FSB_SEC_MSB 13
`define FSB_A_CMD 8'h00
`define FSB_A_ADDR 8'h04
`define FSB_A_DATA 8'h08
`define FSB_A_STAT 8'h0C
`define FSB_A_SEC 8'h10
`define FSB_A_VEC 8'h14
`define FSB_A_BOOT 8'h18
`define FSB_A_UCFG 8'h1C
`define FSB_A_RSTV 8'h20
`define FSB_RP 0
`define FSB_PEL 1
`define FSB_EL 2
`define FSB_BSB 0
`define FSB_AWP 5
`define FSB_CWP 6
`define FSB_GUARD_CLEAR_LOCK 7
`define FSB_ST_VIOL 0
`define FSB_ST_REF 1
`define FSB_ST_CRCINV 2
`define FSB_GUARD_KEY 8'h96
`define FSB_INVALID 8'hFF
`define FSB_VEC_RST 5'h1F
`define FSB_BOOT_RST 8'h01
`define FSB_BOOT_MASK 8'hE1
`define FSB_BOOT_STICKY 8'hC0
`define FSB_UCFG_RST 8'h00
`endif

/* File: src/fsb_pkg.sv */
// types for the flash sector security and boot configuration block
// assumes nothing beyond the defines header
package fsb_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_PROG = 4'h1, OP_ERPG = 4'h2, OP_ERSEC = 4'h3,
    OP_ERGLB = 4'h4, OP_CRCSEC = 4'h5, OP_CRCGLB = 4'h6, OP_PSEC = 4'h7,
    OP_PVEC = 4'h8, OP_PBOOT = 4'h9, OP_PUCFG = 4'hA, OP_CLR_GUARD = 4'hB,
    OP_WE_SET = 4'hC, OP_WE_CLR = 4'hD
  } fsb_op_t;
  typedef enum logic [1:0] {
    MODE_INSYS = 2'b00, MODE_INAPP = 2'b01, MODE_INCIRC = 2'b10, MODE_PARALLEL = 2'b11
  } fsb_mode_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_WAIT_DATA = 1'b1} fsb_state_t;
  typedef struct packed {
    logic valid;
    fsb_op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } fsb_flash_op_t;
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } fsb_code_rd_t;
  function automatic logic fsb_is_ext(input fsb_mode_t m);
    return (m == MODE_INCIRC) || (m == MODE_PARALLEL);
  endfunction
  function automatic logic fsb_needs_data(input fsb_op_t op);
    return (op == OP_PROG) || (op == OP_PSEC) || (op == OP_PVEC) ||
           (op == OP_PBOOT) || (op == OP_PUCFG) || (op == OP_CLR_GUARD);
  endfunction
endpackage

/* File: src/fsb_ahb_slave.sv */
// AHB-Lite slave front end, zero wait states, always OKAY
// assumes single word transfers; hsize is not checked
`timescale 1ns/1ps
module fsb_ahb_slave import fsb_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data
);
  logic act;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  assign act = hsel & htrans[1] & hready;
  assign rd_addr = haddr[7:0];
  assign wr_en = wr_pend_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = hwdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  // read data sampled at the address phase so it stands in the data phase
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= act & hwrite;
      if (act) wr_addr_q <= haddr[7:0];
      hrdata_q <= (act & ~hwrite) ? rd_data : 32'h0000_0000;
    end
  end
endmodule

/* File: src/fsb_sec_check.sv */
// security decision for one command against one sector
// assumes inputs are stable in the cycle the command executes
`timescale 1ns/1ps
`include "fsb_defines.svh"
module fsb_sec_check import fsb_pkg::*; (
  input fsb_op_t op,
  input wire logic [2:0] sec,
  input wire logic any_rp,
  input fsb_mode_t mode,
  input wire logic we_flag,
  input wire logic config_write_guard,
  input wire logic guard_clear_lock,
  input wire logic key_ok,
  output logic viol,
  output logic refuse
);
  logic ext;
  logic prog_like;
  logic mem_wr;
  assign ext = fsb_is_ext(mode);
  assign prog_like = (op == OP_PROG) || (op == OP_ERPG);
  assign mem_wr = prog_like || (op == OP_ERSEC) || (op == OP_ERGLB) || (op == OP_PSEC);
  // read-protect never enters the program/erase terms
  assign viol = (prog_like && (sec[`FSB_PEL] || sec[`FSB_EL])) ||
                ((op == OP_ERSEC) && sec[`FSB_EL]) ||
                ((op == OP_CRCSEC) && sec[`FSB_RP]) ||
                ((op == OP_CRCGLB) && any_rp);
  assign refuse = (mem_wr && !we_flag) ||
                  ((op == OP_ERGLB) && !ext) ||
                  (((op == OP_PVEC) || (op == OP_PBOOT) || (op == OP_PUCFG)) && config_write_guard) ||
                  ((op == OP_CLR_GUARD) && ((guard_clear_lock && !ext) || !key_ok));
endmodule

/* File: src/fsb_top.sv */
// flash sector security and boot configuration, AHB-Lite register slave
// assumes the flash array acts on flash_op pulses and feeds code reads
`timescale 1ns/1ps
`include "fsb_defines.svh"
module fsb_top import fsb_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input fsb_mode_t prog_mode,
  input wire logic core_rst_req,
  input fsb_code_rd_t code_rd,
  output logic [7:0] code_rd_data,
  output logic code_rd_valid,
  output fsb_flash_op_t flash_op,
  output logic [15:0] reset_vector,
  output logic write_enable
);
  // ************************************************
  // bus front end
  // ************************************************
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;

  fsb_ahb_slave u_bus (
    .mclk(mclk),
    .arst_n(arst_n),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .haddr(haddr),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // ************************************************
  // state
  // ************************************************
  logic [2:0] sec_q [`FSB_NSEC];
  logic [4:0] vec_q;
  logic [7:0] boot_q;
  logic [7:0] ucfg_q;
  logic we_q;
  logic viol_q;
  logic ref_q;
  logic crcinv_q;
  fsb_op_t cmd_q;
  logic [15:0] addr_q;
  logic [7:0] data_q;
  fsb_state_t st_q;
  fsb_state_t st_d;
  logic booted_q;
  logic [15:0] rstv_q;
  fsb_flash_op_t fop_q;
  logic [7:0] crd_q;
  logic crv_q;

  // ************************************************
  // command decode
  // ************************************************
  logic wr_cmd;
  logic wr_adr;
  logic wr_dat;
  logic wr_st;
  fsb_op_t cmd_op;
  logic exec_v;
  fsb_op_t exec_op;
  logic [7:0] exec_data;
  logic [3:0] sector;
  logic [2:0] cur_sec;
  logic [`FSB_NSEC-1:0] rp_vec;
  logic any_rp;
  logic viol;
  logic refuse;
  logic ok;
  logic is_mem_op;

  assign wr_cmd = wr_en && (wr_addr == `FSB_A_CMD);
  assign wr_adr = wr_en && (wr_addr == `FSB_A_ADDR);
  assign wr_dat = wr_en && (wr_addr == `FSB_A_DATA);
  assign wr_st = wr_en && (wr_addr == `FSB_A_STAT);
  assign cmd_op = fsb_op_t'(wr_data[3:0]);
  // a command that takes data waits for the data register write
  assign exec_v = (wr_cmd && !fsb_needs_data(cmd_op)) ||
                  (wr_dat && (st_q == ST_WAIT_DATA));
  assign exec_op = wr_cmd ? cmd_op : cmd_q;
  assign exec_data = wr_dat ? wr_data[7:0] : data_q;
  assign sector = addr_q[`FSB_SEC_MSB:`FSB_SEC_LSB];
  assign cur_sec = sec_q[sector];
  assign any_rp = |rp_vec;
  assign ok = exec_v && !viol && !refuse;
  assign is_mem_op = (exec_op == OP_PROG) || (exec_op == OP_ERPG) ||
                     (exec_op == OP_ERSEC) || (exec_op == OP_ERGLB) ||
                     (exec_op == OP_CRCSEC) || (exec_op == OP_CRCGLB);

  fsb_sec_check u_check (
    .op(exec_op),
    .sec(cur_sec),
    .any_rp(any_rp),
    .mode(prog_mode),
    .we_flag(we_q),
    .config_write_guard(boot_q[`FSB_CWP]),
    .guard_clear_lock(boot_q[`FSB_GUARD_CLEAR_LOCK]),
    .key_ok(exec_data == `FSB_GUARD_KEY),
    .viol(viol),
    .refuse(refuse)
  );

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (wr_cmd && fsb_needs_data(cmd_op)) st_d = ST_WAIT_DATA;
      end
      ST_WAIT_DATA: begin
        if (wr_cmd && !fsb_needs_data(cmd_op)) st_d = ST_IDLE;
        else if (wr_dat) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      cmd_q <= OP_NONE;
      addr_q <= 16'h0000;
      data_q <= 8'h00;
    end else begin
      st_q <= st_d;
      if (wr_cmd) cmd_q <= cmd_op;
      if (wr_adr) addr_q <= wr_data[15:0];
      if (wr_dat) data_q <= wr_data[7:0];
    end
  end

  // ************************************************
  // sector security bytes
  // ************************************************
  // programming only sets bits; clearing needs an erase of the sector
  genvar gi;
  generate
    for (gi = 0; gi < `FSB_NSEC; gi++) begin : g_sec
      logic hit;
      assign hit = (sector == 4'(gi));
      assign rp_vec[gi] = sec_q[gi][`FSB_RP];
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          sec_q[gi] <= 3'b000;
        end else if (ok && (exec_op == OP_ERGLB)) begin
          sec_q[gi] <= 3'b000;
        end else if (ok && hit && (exec_op == OP_ERSEC)) begin
          sec_q[gi] <= 3'b000;
        end else if (ok && hit && (exec_op == OP_PSEC)) begin
          sec_q[gi] <= sec_q[gi] | exec_data[2:0];
        end
      end
    end
  endgenerate

  // ************************************************
  // boot and configuration bytes
  // ************************************************
  logic [7:0] boot_d;
  logic ext;
  assign ext = fsb_is_ext(prog_mode);
  // config guard and clear lock bits only go up by programming; write guard follows the written byte
  assign boot_d = (ok && (exec_op == OP_PBOOT)) ?
                  ((boot_q & `FSB_BOOT_STICKY) | (exec_data & `FSB_BOOT_MASK)) :
                  (ok && (exec_op == OP_CLR_GUARD)) ?
                  (boot_q & ~{ext, 1'b1, 6'b00_0000}) :
                  boot_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vec_q <= `FSB_VEC_RST;
      boot_q <= `FSB_BOOT_RST;
      ucfg_q <= `FSB_UCFG_RST;
    end else begin
      boot_q <= boot_d;
      if (ok && (exec_op == OP_PVEC)) vec_q <= exec_data[4:0];
      if (ok && (exec_op == OP_PUCFG)) ucfg_q <= exec_data;
    end
  end

  // ************************************************
  // write enable flag
  // ************************************************
  logic we_d;
  assign we_d = !boot_q[`FSB_AWP] ? 1'b1 :
                (exec_v && (exec_op == OP_WE_SET)) ? 1'b1 :
                (exec_v && (exec_op == OP_WE_CLR)) ? 1'b0 :
                we_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) we_q <= 1'b1;
    else we_q <= we_d;
  end
  assign write_enable = we_q;

  // ************************************************
  // status flags, set wins over clear
  // ************************************************
  logic viol_d;
  logic ref_d;
  logic crcinv_d;
  logic crc_op;
  assign crc_op = exec_v && ((exec_op == OP_CRCSEC) || (exec_op == OP_CRCGLB));
  assign viol_d = (exec_v && viol) ||
                  (viol_q && !(wr_st && wr_data[`FSB_ST_VIOL]));
  assign ref_d = (exec_v && refuse) || (ref_q && !(wr_st && wr_data[`FSB_ST_REF]));
  assign crcinv_d = (crc_op && viol) ? 1'b1 :
                    (crc_op && ok) ? 1'b0 :
                    (crcinv_q && !(wr_st && wr_data[`FSB_ST_CRCINV]));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      viol_q <= 1'b0;
      ref_q <= 1'b0;
      crcinv_q <= 1'b0;
    end else begin
      viol_q <= viol_d;
      ref_q <= ref_d;
      crcinv_q <= crcinv_d;
    end
  end

  // ************************************************
  // flash operation pulse and code reads
  // ************************************************
  logic [3:0] rd_sector;
  logic rd_blocked;
  assign rd_sector = code_rd.addr[`FSB_SEC_MSB:`FSB_SEC_LSB];
  assign rd_blocked = sec_q[rd_sector][`FSB_RP];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fop_q <= '0;
      crd_q <= 8'h00;
      crv_q <= 1'b0;
    end else begin
      fop_q <= '{valid: ok && is_mem_op, op: exec_op, addr: addr_q, data: exec_data};
      crv_q <= code_rd.valid;
      if (code_rd.valid) crd_q <= rd_blocked ? `FSB_INVALID : code_rd.data;
    end
  end
  assign flash_op = fop_q;
  assign code_rd_data = crd_q;
  assign code_rd_valid = crv_q;

  // ************************************************
  // reset vector
  // ************************************************
  // caught after the release and on every core reset request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      booted_q <= 1'b0;
      rstv_q <= 16'h0000;
    end else begin
      booted_q <= 1'b1;
      if (!booted_q || core_rst_req) begin
        rstv_q <= boot_q[`FSB_BSB] ? {3'b000, vec_q, 8'h00} : 16'h0000;
      end
    end
  end
  assign reset_vector = rstv_q;

  // ************************************************
  // register read mux
  // ************************************************
  assign rd_data = (rd_addr == `FSB_A_CMD) ? {28'h000_0000, cmd_q} :
                   (rd_addr == `FSB_A_ADDR) ? {16'h0000, addr_q} :
                   (rd_addr == `FSB_A_DATA) ? {24'h00_0000, data_q} :
                   (rd_addr == `FSB_A_STAT) ? {27'h000_0000, st_q, we_q, crcinv_q, ref_q, viol_q} :
                   (rd_addr == `FSB_A_SEC) ? {29'h0000_0000, cur_sec} :
                   (rd_addr == `FSB_A_VEC) ? {27'h000_0000, vec_q} :
                   (rd_addr == `FSB_A_BOOT) ? {24'h00_0000, boot_q} :
                   (rd_addr == `FSB_A_UCFG) ? {24'h00_0000, ucfg_q} :
                   (rd_addr == `FSB_A_RSTV) ? {16'h0000, rstv_q} :
                   32'h0000_0000;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_read_invalid: assert property (code_rd.valid && rd_blocked |=> code_rd_data == 8'hFF)
    else $error("protected code read returned stored data");
  a_guard_forces_we: assert property (!boot_q[`FSB_AWP] |=> we_q)
    else $error("write enable not forced while guard inactive");
  a_we_cmd_only: assert property (boot_q[`FSB_AWP] && !(exec_v && ((exec_op == OP_WE_SET) ||
      (exec_op == OP_WE_CLR))) |=> $stable(we_q))
    else $error("write enable changed without command");
  a_viol_sticky: assert property (viol_q && !wr_st |=> viol_q)
    else $error("violation flag dropped without clear");
  a_crc_sector: assert property (exec_v && exec_op == OP_CRCSEC && cur_sec[0]
      |=> viol_q && crcinv_q && !flash_op.valid)
    else $error("sector crc on protected sector not aborted");
  a_crc_global: assert property (exec_v && exec_op == OP_CRCGLB && any_rp
      |=> viol_q && !flash_op.valid)
    else $error("global crc not aborted");
  a_rp_no_viol: assert property (exec_v && exec_op == OP_ERPG && cur_sec == 3'b001 && we_q
      |=> flash_op.valid)
    else $error("read protect alone blocked page erase");
  a_lock_prog: assert property (exec_v && exec_op == OP_PROG && cur_sec[1]
      |=> viol_q && !flash_op.valid)
    else $error("program into locked sector not aborted");
  a_lock_sec_erase: assert property (exec_v && exec_op == OP_ERSEC && cur_sec == 3'b010 && we_q
      |=> flash_op.valid ##0 flash_op.op == OP_ERSEC)
    else $error("sector erase refused under program lock");
  a_erase_lock: assert property (exec_v && exec_op == OP_ERSEC && cur_sec[2]
      |=> !flash_op.valid ##0 sec_q[$past(sector)] == $past(cur_sec))
    else $error("erase locked sector was erased");
  a_cfg_guard: assert property (exec_v && exec_op == OP_PVEC && boot_q[`FSB_CWP]
      |=> $stable(vec_q) && ref_q)
    else $error("boot vector written under guard");
  a_clear_lock: assert property (exec_v && exec_op == OP_CLR_GUARD && boot_q[`FSB_GUARD_CLEAR_LOCK] &&
      !ext |=> boot_q[`FSB_CWP] == $past(boot_q[`FSB_CWP]))
    else $error("clear command accepted under clear lock");
  a_boot_addr: assert property (!booted_q && boot_q[`FSB_BSB]
      |=> rstv_q == {3'b000, $past(vec_q), 8'h00})
    else $error("boot vector not taken after reset");

  c_prog_ok: cover property (exec_v && exec_op == OP_PROG ##1 flash_op.valid);
  c_read_blocked: cover property (code_rd.valid && rd_blocked);
  c_guard_cleared: cover property (boot_q[`FSB_CWP] ##[1:20] !boot_q[`FSB_CWP]);
  c_global_erase: cover property (ok && exec_op == OP_ERGLB);
endmodule

/* File: verification/fsb_flash_model.sv */
// flash array stand-in: applies accepted flash operations, serves code reads
// assumes flash_op pulses for one cycle; page erase leaves the array alone
`timescale 1ns/1ps
module fsb_flash_model import fsb_pkg::*; (
  input wire logic mclk,
  input fsb_flash_op_t flash_op,
  output fsb_code_rd_t code_rd
);
  logic [7:0] mem_q [0:16383];

  initial begin
    code_rd = '0;
    foreach (mem_q[i]) mem_q[i] = 8'hff;
  end

  always @(posedge mclk) begin
    if (flash_op.valid === 1'b1) begin
      case (flash_op.op)
        OP_PROG: mem_q[flash_op.addr[13:0]] = flash_op.data;
        OP_ERSEC: for (int i = 0; i < 1024; i++) mem_q[{flash_op.addr[13:10], i[9:0]}] = 8'hff;
        OP_ERGLB: foreach (mem_q[i]) mem_q[i] = 8'hff;
        default: ;
      endcase
    end
  end

  // released bus shows inverted values so a stale byte cannot pass
  task automatic fetch(input logic [15:0] a);
    // extra edge so a program pulse just issued has landed in the array
    repeat (2) @(posedge mclk);
    code_rd <= '{valid: 1'b1, addr: a, data: mem_q[a[13:0]]};
    @(posedge mclk);
    code_rd <= '{valid: 1'b0, addr: ~a, data: ~mem_q[a[13:0]]};
  endtask
endmodule

/* File: verification/tb_flash_sector_security_boot_cfg.sv */
// testbench for the flash sector security and boot configuration block
// assumes a zero-wait AHB-Lite slave and the flash stand-in as far side
`timescale 1ns/1ps
`include "fsb_defines.svh"
module tb_flash_sector_security_boot_cfg import fsb_pkg::*;;
  typedef struct packed {
    logic [2:0] sec;
    fsb_op_t op;
    fsb_mode_t mode;
    logic [2:0] st;
    logic pulse;
  } fsb_row_t;
  logic mclk, arst_n, hsel, hwrite, core_rst_req;
  logic hreadyout, hresp, code_rd_valid, write_enable;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [7:0] code_rd_data;
  logic [15:0] reset_vector;
  fsb_mode_t prog_mode;
  fsb_code_rd_t code_rd;
  fsb_flash_op_t flash_op;
  fsb_op_t last_op;
  fsb_row_t rows [16];
  int fail_count, checks, pulses;

  fsb_top dut_u (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .haddr(haddr), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .prog_mode(prog_mode), .core_rst_req(core_rst_req),
    .code_rd(code_rd), .code_rd_data(code_rd_data), .code_rd_valid(code_rd_valid),
    .flash_op(flash_op), .reset_vector(reset_vector), .write_enable(write_enable));
  fsb_flash_model flash_u (.mclk(mclk), .flash_op(flash_op), .code_rd(code_rd));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (flash_op.valid === 1'b1) begin
      pulses++;
      last_op = flash_op.op;
    end
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // each transfer starts with an idle cycle so reads never see stale muxes
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hffff_ffff);
    xfer(1'b0, a, 32'h0000_0000);
    chk(n, e, rdv & m);
  endtask

  task automatic cmd(input fsb_op_t op, input logic [7:0] d = 8'h00);
    xfer(1'b1, `FSB_A_CMD, 32'(op));
    if (op inside {OP_PROG, OP_PSEC, OP_PVEC, OP_PBOOT, OP_PUCFG, OP_CLR_GUARD}) begin
      xfer(1'b1, `FSB_A_DATA, 32'(d));
    end
  endtask

  task automatic core_reset();
    @(posedge mclk);
    core_rst_req <= 1'b1;
    @(posedge mclk);
    core_rst_req <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {hsel, hwrite, core_rst_req, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    prog_mode = MODE_INSYS;
    arst_n = 1'b0;
    rows = '{
      '{3'h0, OP_PROG, MODE_INSYS, 3'h0, 1'b1}, '{3'h1, OP_PROG, MODE_INSYS, 3'h0, 1'b1},
      '{3'h1, OP_ERPG, MODE_INAPP, 3'h0, 1'b1}, '{3'h1, OP_CRCSEC, MODE_INSYS, 3'h5, 1'b0},
      '{3'h1, OP_CRCGLB, MODE_INSYS, 3'h5, 1'b0}, '{3'h2, OP_PROG, MODE_INSYS, 3'h1, 1'b0},
      '{3'h2, OP_ERPG, MODE_INAPP, 3'h1, 1'b0}, '{3'h2, OP_ERSEC, MODE_INSYS, 3'h0, 1'b1},
      '{3'h4, OP_PROG, MODE_INAPP, 3'h1, 1'b0}, '{3'h4, OP_ERPG, MODE_INSYS, 3'h1, 1'b0},
      '{3'h4, OP_ERSEC, MODE_INAPP, 3'h1, 1'b0}, '{3'h4, OP_ERGLB, MODE_INSYS, 3'h2, 1'b0},
      '{3'h4, OP_ERGLB, MODE_INCIRC, 3'h0, 1'b1}, '{3'h6, OP_ERGLB, MODE_PARALLEL, 3'h0, 1'b1},
      '{3'h0, OP_CRCSEC, MODE_INSYS, 3'h0, 1'b1}, '{3'h4, OP_ERSEC, MODE_INCIRC, 3'h1, 1'b0}};
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    xfer(1'b1, `FSB_A_ADDR, 32'h0000_0834);
    foreach (rows[i]) begin
      prog_mode <= MODE_INCIRC;
      cmd(OP_ERGLB);
      xfer(1'b1, `FSB_A_STAT, 32'h0000_0007);
      cmd(OP_PSEC, {5'h00, rows[i].sec});
      rd_chk("sec byte", `FSB_A_SEC, 32'(rows[i].sec), 32'h0000_0007);
      prog_mode <= rows[i].mode;
      pulses = 0;
      cmd(rows[i].op, 8'h5a);
      rd_chk("status", `FSB_A_STAT, 32'(rows[i].st), 32'h0000_0007);
      chk("op pulses", 32'(rows[i].pulse), 32'(pulses));
      if (rows[i].pulse) chk("op code", 32'(rows[i].op), 32'(last_op));
    end
    // ****************************************
    // hand-written cases
    // ****************************************
    prog_mode <= MODE_INCIRC;
    cmd(OP_ERGLB);
    rd_chk("sticky", `FSB_A_STAT, 32'h0000_0001, 32'h0000_0007);
    xfer(1'b1, `FSB_A_STAT, 32'h0000_0007);
    rd_chk("cleared", `FSB_A_STAT, 32'h0000_0000, 32'h0000_0007);
    cmd(OP_PROG, 8'ha5);
    flash_u.fetch(16'h0834);
    @(negedge mclk);
    chk("code valid", 32'h0000_0001, 32'(code_rd_valid));
    chk("code data", 32'h0000_00a5, 32'(code_rd_data));
    cmd(OP_PSEC, 8'h01);
    flash_u.fetch(16'h0834);
    @(negedge mclk);
    chk("code hidden", 32'h0000_00ff, 32'(code_rd_data));
    cmd(OP_ERSEC);
    rd_chk("rp erased", `FSB_A_SEC, 32'h0000_0000, 32'h0000_0007);
    cmd(OP_WE_CLR);
    repeat (2) @(negedge mclk);
    chk("we forced", 32'h0000_0001, 32'(write_enable));
    cmd(OP_PBOOT, 8'h21);
    cmd(OP_WE_CLR);
    repeat (2) @(negedge mclk);
    chk("we clear", 32'h0000_0000, 32'(write_enable));
    cmd(OP_WE_SET);
    repeat (2) @(negedge mclk);
    chk("we set", 32'h0000_0001, 32'(write_enable));
    prog_mode <= MODE_INSYS;
    cmd(OP_PBOOT, 8'hc1);
    rd_chk("boot", `FSB_A_BOOT, 32'h0000_00c1, 32'h0000_00ff);
    cmd(OP_PVEC, 8'h05);
    rd_chk("vec kept", `FSB_A_VEC, 32'h0000_001f, 32'h0000_001f);
    cmd(OP_PUCFG, 8'h5a);
    rd_chk("ucfg kept", `FSB_A_UCFG, 32'h0000_0000, 32'h0000_00ff);
    cmd(OP_CLR_GUARD, 8'h96);
    rd_chk("lock holds", `FSB_A_BOOT, 32'h0000_00c1, 32'h0000_00ff);
    prog_mode <= MODE_INCIRC;
    cmd(OP_CLR_GUARD, 8'h95);
    rd_chk("bad key", `FSB_A_BOOT, 32'h0000_00c1, 32'h0000_00ff);
    cmd(OP_CLR_GUARD, 8'h96);
    rd_chk("unlocked", `FSB_A_BOOT, 32'h0000_0001, 32'h0000_00ff);
    cmd(OP_PVEC, 8'h05);
    rd_chk("vec new", `FSB_A_VEC, 32'h0000_0005, 32'h0000_001f);
    cmd(OP_PUCFG, 8'h5a);
    rd_chk("ucfg new", `FSB_A_UCFG, 32'h0000_005a, 32'h0000_00ff);
    core_reset();
    chk("boot addr", 32'h0000_0500, 32'(reset_vector));
    cmd(OP_PBOOT, 8'h00);
    core_reset();
    chk("no boot", 32'h0000_0000, 32'(reset_vector));
    // second reset brings the factory configuration back
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    rd_chk("vec reset", `FSB_A_VEC, 32'h0000_001f);
    rd_chk("boot reset", `FSB_A_BOOT, 32'h0000_0001);
    rd_chk("sec reset", `FSB_A_SEC, 32'h0000_0000);
    rd_chk("ucfg reset", `FSB_A_UCFG, 32'h0000_0000);
    chk("rst vec", 32'h0000_1f00, 32'(reset_vector));
    xfer(1'b1, 8'h40, 32'h0000_00ff);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, 32'(hresp));
    tally_and_finish();
  end
endmodule
